// *** hw/apsl_alarm_setup.sv ***
// Alarm pin routing, masking and latching with APB registers
`timescale 1ns/10ps

// Function
// R01 - Disabled source never drives its pin; live status still reports it.
// R02 - Bit 15 high latches the temperature pin; low follows the condition.
// R03 - Bit 14 high keeps the temperature pin released.
// R04 - Bit 13 high makes open-sense a latched contribution to combined pin.
// R05 - Bit 12 high blocks open-sense from the combined pin.
// R06 - Combined pin is driven by enabled open-sense, load and guard alarms.
// R07 - Bit 11 high makes load alarm a latched combined pin contribution.
// R08 - Bit 10 high blocks the load alarm from the combined pin.
// R09 - Bit 10 high also switches off the load ground sense pull-up.
// R10 - Bit 9 high latches the clamp pin; low follows the condition.
// R11 - Bit 8 high keeps the clamp pin released.
// R12 - Bit 7 high makes guard alarm a latched combined pin contribution.
// R13 - Bit 6 high blocks the guard alarm from the combined pin.
// R14 - Host writes zero to bits 5..0; device ignores them, reads zero.
// R15 - Latched pins hold until explicit clear; unlatched release at once.
module apsl_alarm_setup
	import apsl_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APSL_AW-1:0] paddr,
	input wire logic [APSL_DW-1:0] pwdata,
	output logic [APSL_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Raw alarm conditions from the detectors, asynchronous
	input wire logic [APSL_NSRC-1:0] alarm_cond,
	// Open-drain temperature alarm pin
	input wire logic temperature_alarm_pin_i,
	output logic temperature_alarm_pin_o,
	output logic temperature_alarm_pin_oe,
	// Open-drain clamp alarm pin
	input wire logic clamp_alarm_pin_i,
	output logic clamp_alarm_pin_o,
	output logic clamp_alarm_pin_oe,
	// Open-drain combined sense alarm pin
	input wire logic combined_sense_alarm_pin_i,
	output logic combined_sense_alarm_pin_o,
	output logic combined_sense_alarm_pin_oe,
	// Load ground sense pull-up enable
	output logic load_ground_pullup_en,
	// Interrupt
	output logic alarm_irq
);

	// Byte address match for a register index
	function automatic logic reg_hit(input logic [APSL_AW-1:0] a,
		input logic [APSL_AW-1:0] idx);
		return a == {idx[APSL_AW-3:0], 2'b00};
	endfunction : reg_hit

	logic [APSL_NSRC-1:0] cond_meta;
	logic [APSL_NSRC-1:0] cond_s;
	logic [APSL_NSRC-1:0] cond_d;
	logic [APSL_NPIN-1:0] pin_meta;
	logic [APSL_NPIN-1:0] pin_s;
	logic [15:0] alarm_setup;
	logic [APSL_NSRC-1:0] latch_hold;
	logic [APSL_NSRC-1:0] irq_status;
	logic [APSL_NSRC-1:0] irq_enable;
	logic [APSL_NSRC-1:0] src_lat;
	logic [APSL_NSRC-1:0] src_dis;
	logic [APSL_NSRC-1:0] active;
	logic [APSL_NSRC-1:0] contrib;
	logic [APSL_NSRC-1:0] latch_clr;
	logic [APSL_NSRC-1:0] irq_clr;
	logic [APSL_NSRC-1:0] next_latch;
	logic [APSL_NSRC-1:0] next_irq_status;
	logic wr_acc;
	logic setup_ph;

	// Two-flop synchronisers; detectors and pins are not on core_clk
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cond_meta <= '0;
			cond_s <= '0;
			cond_d <= '0;
			pin_meta <= '0;
			pin_s <= '0;
		end else begin
			cond_meta <= alarm_cond;
			cond_s <= cond_meta;
			cond_d <= cond_s;
			pin_meta <= {combined_sense_alarm_pin_i, clamp_alarm_pin_i,
				temperature_alarm_pin_i};
			pin_s <= pin_meta;
		end
	end

	// Bus phase decode; slave never waits, so pready is high from the first cycle after reset
	assign wr_acc = psel && penable && pready && pwrite;
	assign setup_ph = psel && !penable;

	// Per-source latch and disable selects from the setup word
	assign src_lat = {alarm_setup[APSL_B_GRD_LAT],
		alarm_setup[APSL_B_LOAD_LAT], alarm_setup[APSL_B_OPEN_LAT],
		alarm_setup[APSL_B_CLAMP_LAT], alarm_setup[APSL_B_TMP_LAT]};
	assign src_dis = {alarm_setup[APSL_B_GRD_DIS],
		alarm_setup[APSL_B_LOAD_DIS], alarm_setup[APSL_B_OPEN_DIS],
		alarm_setup[APSL_B_CLAMP_DIS], alarm_setup[APSL_B_TMP_DIS]};

	// Write strobes of the clear registers
	assign latch_clr = (wr_acc && reg_hit(paddr, APSL_IDX_LATCH_CLR)) ?
		pwdata[APSL_NSRC-1:0] : '0;
	assign irq_clr = (wr_acc && reg_hit(paddr, APSL_IDX_IRQ_CLR)) ?
		pwdata[APSL_NSRC-1:0] : '0;

	// Enabled sources only; masking never touches the live status field
	assign active = cond_s & ~src_dis; // [R01] [R05] [R08] [R13]
	// New hit sets the latch even while it is being cleared
	assign next_latch = ((latch_hold & ~latch_clr) | active) & src_lat; // [R15]
	// Held contribution is dropped at once if its source is disabled
	assign contrib = active | (latch_hold & src_lat & ~src_dis); // [R02] [R10]

	// Latch per source, meaningful only in latched mode
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_hold <= '0;
		end else begin
			latch_hold <= next_latch; // [R04] [R07] [R12] [R15]
		end
	end

	// Pin drivers; pins pull low when oe is high, so data is always 0
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			temperature_alarm_pin_o <= 1'b0;
			temperature_alarm_pin_oe <= 1'b0;
			clamp_alarm_pin_o <= 1'b0;
			clamp_alarm_pin_oe <= 1'b0;
			combined_sense_alarm_pin_o <= 1'b0;
			combined_sense_alarm_pin_oe <= 1'b0;
		end else begin
			temperature_alarm_pin_o <= 1'b0;
			clamp_alarm_pin_o <= 1'b0;
			combined_sense_alarm_pin_o <= 1'b0;
			temperature_alarm_pin_oe <= contrib[APSL_SRC_TMP]; // [R03]
			clamp_alarm_pin_oe <= contrib[APSL_SRC_CLAMP]; // [R11]
			combined_sense_alarm_pin_oe <= contrib[APSL_SRC_OPEN] |
				contrib[APSL_SRC_LOAD] | contrib[APSL_SRC_GRD]; // [R06]
		end
	end

	// Pull-up follows the load disable bit
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			load_ground_pullup_en <= 1'b1;
		end else begin
			load_ground_pullup_en <= !alarm_setup[APSL_B_LOAD_DIS]; // [R09]
		end
	end

	// Setup and interrupt enable registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			alarm_setup <= APSL_SETUP_RST;
			irq_enable <= '0;
		end else if (wr_acc) begin
			if (reg_hit(paddr, APSL_IDX_SETUP)) begin
				alarm_setup <= pwdata[15:0] & APSL_SETUP_WMASK; // [R14]
			end else if (reg_hit(paddr, APSL_IDX_IRQ_EN)) begin
				irq_enable <= pwdata[APSL_NSRC-1:0];
			end
		end
	end

	// Sticky rising-edge events; a new edge beats a same-cycle clear
	assign next_irq_status = (irq_status & ~irq_clr) | (cond_s & ~cond_d);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_status <= '0;
			alarm_irq <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			alarm_irq <= |(irq_status & irq_enable);
		end
	end

	// Read data and error taken in the setup phase, shown in access
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= '0;
			pslverr <= 1'b0;
			pready <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (setup_ph) begin
				pslverr <= 1'b0;
				prdata <= '0;
				if (reg_hit(paddr, APSL_IDX_SETUP)) begin
					prdata[15:0] <= alarm_setup; // [R14]
				end else if (reg_hit(paddr, APSL_IDX_STATUS)) begin
					prdata[APSL_ST_LIVE +: APSL_NSRC] <= cond_s; // [R01]
					prdata[APSL_ST_HELD +: APSL_NSRC] <= latch_hold;
					prdata[APSL_ST_PIN +: APSL_NPIN] <= pin_s;
				end else if (reg_hit(paddr, APSL_IDX_IRQ_STAT)) begin
					prdata[APSL_NSRC-1:0] <= irq_status;
				end else if (reg_hit(paddr, APSL_IDX_IRQ_EN)) begin
					prdata[APSL_NSRC-1:0] <= irq_enable;
				end else if (reg_hit(paddr, APSL_IDX_LATCH_CLR) ||
					reg_hit(paddr, APSL_IDX_IRQ_CLR)) begin
					prdata <= '0;
				end else begin
					pslverr <= 1'b1;
				end
			end
		end
	end

	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// Source hit in latched mode, then mode held and no clear
	sequence s_latched(int lb, int db, int src);
		alarm_setup[lb] && !alarm_setup[db] && cond_s[src] ##1
		alarm_setup[lb] && !alarm_setup[db] && !latch_clr[src];
	endsequence

	property p_r01;
		setup_ph && reg_hit(paddr, APSL_IDX_STATUS) |=>
			prdata[APSL_NSRC-1:0] == $past(cond_s);
	endproperty
	a_r01: assert property (p_r01) else $error("status lost"); // [R01]

	property p_r02;
		s_latched(APSL_B_TMP_LAT, APSL_B_TMP_DIS, APSL_SRC_TMP) |=>
			temperature_alarm_pin_oe;
	endproperty
	a_r02: assert property (p_r02) else $error("temp not held"); // [R02]

	property p_r02u;
		!alarm_setup[APSL_B_TMP_LAT] && !cond_s[APSL_SRC_TMP] |=>
			!temperature_alarm_pin_oe;
	endproperty
	a_r02u: assert property (p_r02u) else $error("temp stuck"); // [R02]

	property p_r03;
		alarm_setup[APSL_B_TMP_DIS] |=> !temperature_alarm_pin_oe;
	endproperty
	a_r03: assert property (p_r03) else $error("temp disabled"); // [R03]

	property p_r04;
		s_latched(APSL_B_OPEN_LAT, APSL_B_OPEN_DIS, APSL_SRC_OPEN) |=>
			combined_sense_alarm_pin_oe;
	endproperty
	a_r04: assert property (p_r04) else $error("open not held"); // [R04]

	property p_r05;
		!alarm_setup[APSL_B_OPEN_DIS] && cond_s[APSL_SRC_OPEN] |=>
			combined_sense_alarm_pin_oe;
	endproperty
	a_r05: assert property (p_r05) else $error("open missed"); // [R05]

	property p_r06;
		alarm_setup[APSL_B_OPEN_DIS] && alarm_setup[APSL_B_LOAD_DIS] &&
			alarm_setup[APSL_B_GRD_DIS] |=> !combined_sense_alarm_pin_oe;
	endproperty
	a_r06: assert property (p_r06) else $error("comb masked"); // [R06]

	property p_r07;
		s_latched(APSL_B_LOAD_LAT, APSL_B_LOAD_DIS, APSL_SRC_LOAD) |=>
			combined_sense_alarm_pin_oe;
	endproperty
	a_r07: assert property (p_r07) else $error("load not held"); // [R07]

	property p_r08;
		!alarm_setup[APSL_B_LOAD_DIS] && cond_s[APSL_SRC_LOAD] |=>
			combined_sense_alarm_pin_oe;
	endproperty
	a_r08: assert property (p_r08) else $error("load missed"); // [R08]

	property p_r09;
		1'b1 |=> load_ground_pullup_en == !$past(alarm_setup[APSL_B_LOAD_DIS]);
	endproperty
	a_r09: assert property (p_r09) else $error("pull-up wrong"); // [R09]

	property p_r10;
		s_latched(APSL_B_CLAMP_LAT, APSL_B_CLAMP_DIS, APSL_SRC_CLAMP) |=>
			clamp_alarm_pin_oe;
	endproperty
	a_r10: assert property (p_r10) else $error("clamp not held"); // [R10]

	property p_r11;
		alarm_setup[APSL_B_CLAMP_DIS] |=> !clamp_alarm_pin_oe;
	endproperty
	a_r11: assert property (p_r11) else $error("clamp disabled"); // [R11]

	property p_r12;
		s_latched(APSL_B_GRD_LAT, APSL_B_GRD_DIS, APSL_SRC_GRD) |=>
			combined_sense_alarm_pin_oe;
	endproperty
	a_r12: assert property (p_r12) else $error("guard not held"); // [R12]

	property p_r13;
		!alarm_setup[APSL_B_GRD_DIS] && cond_s[APSL_SRC_GRD] |=>
			combined_sense_alarm_pin_oe;
	endproperty
	a_r13: assert property (p_r13) else $error("guard missed"); // [R13]

	property p_r15;
		latch_clr[APSL_SRC_TMP] && !cond_s[APSL_SRC_TMP] |=>
			!latch_hold[APSL_SRC_TMP] ##1 !(temperature_alarm_pin_oe &&
			!$past(cond_s[APSL_SRC_TMP]) && !$past(latch_hold[APSL_SRC_TMP]));
	endproperty
	a_r15: assert property (p_r15) else $error("clear failed"); // [R15]

endmodule : apsl_alarm_setup

// *** hw/apsl_pkg.sv ***
// Constants for the alarm pin setup logic
package apsl_pkg;
	// APB address width and data width
	localparam int APSL_AW = 8;
	localparam int APSL_DW = 32;
	// Register indexes; byte address is four times the index
	localparam logic [APSL_AW-1:0] APSL_IDX_SETUP = 8'h06;
	localparam logic [APSL_AW-1:0] APSL_IDX_STATUS = 8'h08;
	localparam logic [APSL_AW-1:0] APSL_IDX_LATCH_CLR = 8'h09;
	localparam logic [APSL_AW-1:0] APSL_IDX_IRQ_STAT = 8'h0A;
	localparam logic [APSL_AW-1:0] APSL_IDX_IRQ_CLR = 8'h0B;
	localparam logic [APSL_AW-1:0] APSL_IDX_IRQ_EN = 8'h0C;
	// Setup register reset value and writable bits
	localparam logic [15:0] APSL_SETUP_RST = 16'h0000;
	localparam logic [15:0] APSL_SETUP_WMASK = 16'hFFC0;
	// Setup register bit positions
	localparam int APSL_B_TMP_LAT = 15;
	localparam int APSL_B_TMP_DIS = 14;
	localparam int APSL_B_OPEN_LAT = 13;
	localparam int APSL_B_OPEN_DIS = 12;
	localparam int APSL_B_LOAD_LAT = 11;
	localparam int APSL_B_LOAD_DIS = 10;
	localparam int APSL_B_CLAMP_LAT = 9;
	localparam int APSL_B_CLAMP_DIS = 8;
	localparam int APSL_B_GRD_LAT = 7;
	localparam int APSL_B_GRD_DIS = 6;
	// Alarm source positions in every source vector
	localparam int APSL_NSRC = 5;
	localparam int APSL_SRC_TMP = 0;
	localparam int APSL_SRC_CLAMP = 1;
	localparam int APSL_SRC_OPEN = 2;
	localparam int APSL_SRC_LOAD = 3;
	localparam int APSL_SRC_GRD = 4;
	// Status register field positions
	localparam int APSL_ST_LIVE = 0;
	localparam int APSL_ST_HELD = 8;
	localparam int APSL_ST_PIN = 16;
	localparam int APSL_NPIN = 3;
endpackage : apsl_pkg

// *** tb/apsl_alarm_setup_test.sv ***
// Self-checking bench for the alarm pin setup logic
`timescale 1ns/10ps
module apsl_alarm_setup_test;
	import apsl_pkg::*;
	logic core_clk = 0;
	logic rst_n = 0;
	logic psel = 0, penable = 0, pwrite = 0;
	logic [APSL_AW-1:0] paddr = '0;
	logic [APSL_DW-1:0] pwdata = '0, prdata;
	logic pready, pslverr, pull_en, irq;
	logic [APSL_NSRC-1:0] alarm_cond = '0;
	logic tmp_o, tmp_oe, tmp_lvl, clp_o, clp_oe, clp_lvl;
	logic cmb_o, cmb_oe, cmb_lvl;
	logic [32:0] q[$];
	int n_fail = 0, checks_done = 0, cyc = 0;
	logic [15:0] s;
	logic [4:0] c;
	localparam int LB[5] = '{15, 9, 13, 11, 7};

	apsl_alarm_setup i_dut (.core_clk(core_clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .alarm_cond(alarm_cond),
		.temperature_alarm_pin_i(tmp_lvl), .temperature_alarm_pin_o(tmp_o),
		.temperature_alarm_pin_oe(tmp_oe), .clamp_alarm_pin_i(clp_lvl),
		.clamp_alarm_pin_o(clp_o), .clamp_alarm_pin_oe(clp_oe),
		.combined_sense_alarm_pin_i(cmb_lvl),
		.combined_sense_alarm_pin_o(cmb_o),
		.combined_sense_alarm_pin_oe(cmb_oe),
		.load_ground_pullup_en(pull_en), .alarm_irq(irq));
	apsl_pin_host i_host (.tmp_o(tmp_o), .tmp_oe(tmp_oe), .clp_o(clp_o),
		.clp_oe(clp_oe), .cmb_o(cmb_o), .cmb_oe(cmb_oe),
		.tmp_lvl(tmp_lvl), .clp_lvl(clp_lvl), .cmb_lvl(cmb_lvl));

	// Clock at 250 MHz
	initial begin
		forever #2 core_clk = ~core_clk;
	end

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop();
		$display("checks=%0d fails=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop

	// Expected status word: pslverr, pin levels, holds, live conditions
	function automatic logic [32:0] st(logic [15:0] sv, logic [4:0] cv,
		logic [4:0] h);
		logic [4:0] a;
		logic [2:0] p;
		a = cv | h;
		p[0] = a[0] & !sv[14];
		p[1] = a[1] & !sv[8];
		p[2] = (a[2] & !sv[12]) | (a[3] & !sv[10]) | (a[4] & !sv[6]);
		st = {14'h0000, ~p, 3'h0, h, 3'h0, cv};
	endfunction : st

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] idx,
		input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx[5:0], 2'b00};
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1) @(posedge core_clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [7:0] idx, input logic [32:0] exp);
		q.push_back(exp);
		apb(1'b0, idx, 32'h0000_0000);
	endtask : rd

	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask : idle

	// Watcher: each completed read takes the oldest note
	always @(posedge core_clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			check({pslverr, prdata}, q.pop_front());
		end
	end

	// Hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			report_and_stop();
		end
	end

	initial begin
		void'($urandom(32'hF9B38F97));
		idle(3);
		rst_n <= 1'b1;
		rd(APSL_IDX_SETUP, 33'h0);
		check({32'h0, pull_en}, 33'h1);
		$display("test reset done");
		apb(1'b1, APSL_IDX_SETUP, 32'hFFFF_FFFF);
		rd(APSL_IDX_SETUP, 33'h0_0000_FFC0);
		idle(2);
		check({32'h0, pull_en}, 33'h0);
		$display("test setup bits done");
		// Random masks and conditions, no latching
		for (int i = 0; i < 24; i++) begin
			s = 16'($urandom) & 16'h5540;
			c = 5'($urandom);
			apb(1'b1, APSL_IDX_SETUP, {16'h0000, s});
			alarm_cond <= c;
			idle(8);
			rd(APSL_IDX_STATUS, st(s, c, 5'h00));
			check({32'h0, pull_en}, {32'h0, !s[10]});
		end
		$display("test masking done");
		// Latched mode per source, then explicit clear
		for (int i = 0; i < 5; i++) begin
			s = 16'h0001 << LB[i];
			c = 5'h01 << i;
			apb(1'b1, APSL_IDX_SETUP, {16'h0000, s});
			alarm_cond <= c;
			idle(8);
			alarm_cond <= 5'h00;
			idle(8);
			rd(APSL_IDX_STATUS, st(s, 5'h00, c));
			apb(1'b1, APSL_IDX_LATCH_CLR, {27'h0, c});
			idle(8);
			rd(APSL_IDX_STATUS, st(s, 5'h00, 5'h00));
		end
		// Disabling a held temperature alarm must release its pin at once
		apb(1'b1, APSL_IDX_SETUP, 32'h0000_8000);
		alarm_cond <= 5'h01;
		idle(8);
		alarm_cond <= 5'h00;
		apb(1'b1, APSL_IDX_SETUP, 32'h0000_C000);
		idle(8);
		rd(APSL_IDX_STATUS, st(16'hC000, 5'h00, 5'h01));
		apb(1'b1, APSL_IDX_LATCH_CLR, 32'h0000_0001);
		$display("test latching done");
		// Interrupt raise, mask and clear
		apb(1'b1, APSL_IDX_IRQ_CLR, 32'h0000_001F);
		apb(1'b1, APSL_IDX_IRQ_EN, 32'h0000_001F);
		rd(APSL_IDX_IRQ_EN, 33'h1F);
		alarm_cond <= 5'h02;
		idle(8);
		check({32'h0, irq}, 33'h1);
		rd(APSL_IDX_IRQ_STAT, 33'h2);
		apb(1'b1, APSL_IDX_IRQ_EN, 32'h0000_0000);
		rd(APSL_IDX_IRQ_EN, 33'h0);
		idle(3);
		check({32'h0, irq}, 33'h0);
		apb(1'b1, APSL_IDX_IRQ_CLR, 32'h0000_0002);
		rd(APSL_IDX_IRQ_STAT, 33'h0);
		rd(APSL_IDX_LATCH_CLR, 33'h0);
		rd(8'h3F, 33'h1_0000_0000);
		$display("test interrupt done");
		idle(2);
		report_and_stop();
	end
endmodule : apsl_alarm_setup_test

// *** tb/apsl_pin_host.sv ***
// Host side of the three open-drain alarm pins, with board pull-ups
`timescale 1ns/10ps
module apsl_pin_host (
	// Pin drivers from the device
	input wire logic tmp_o,
	input wire logic tmp_oe,
	input wire logic clp_o,
	input wire logic clp_oe,
	input wire logic cmb_o,
	input wire logic cmb_oe,
	// Resolved wire levels seen by every party
	output logic tmp_lvl,
	output logic clp_lvl,
	output logic cmb_lvl
);
	// Released pin floats up to the pull-up, so idle reads high
	assign tmp_lvl = tmp_oe ? tmp_o : 1'b1;
	assign clp_lvl = clp_oe ? clp_o : 1'b1;
	assign cmb_lvl = cmb_oe ? cmb_o : 1'b1;
endmodule : apsl_pin_host
